// ### cais_pkg.sv
package cais_pkg;

   // ======================================================================
   // Four internal clock phases of one instruction cycle.
   typedef enum logic [1:0] {
      CAIS_Q1 = 2'b00,
      CAIS_Q2 = 2'b01,
      CAIS_Q3 = 2'b10,
      CAIS_Q4 = 2'b11
   } cais_phase_t;

   // ======================================================================
   // Decoded instruction classes.
   typedef enum logic [3:0] {
      CAIS_OP_NOP      = 4'h0,
      CAIS_OP_ADD_LIT  = 4'h1,
      CAIS_OP_ADD_FILE = 4'h2,
      CAIS_OP_ADD_CY   = 4'h3,
      CAIS_OP_AND_LIT  = 4'h4,
      CAIS_OP_AND_FILE = 4'h5,
      CAIS_OP_BIT_CLR  = 4'h6,
      CAIS_OP_SET_FILE = 4'h7,
      CAIS_OP_SKIP_CLR = 4'h8,
      CAIS_OP_SKIP_SET = 4'h9,
      CAIS_OP_LONG_CALL = 4'ha,
      CAIS_OP_BRANCH   = 4'hb,
      CAIS_OP_RET      = 4'hc,
      CAIS_OP_TBL_RD   = 4'hd,
      CAIS_OP_TBL_WR   = 4'he
   } cais_op_t;

   // ======================================================================
   // Opcode patterns, compared against the named top bits of the word.
   localparam logic [7:0] OPC_ADD_LIT   = 8'hb1;
   localparam logic [7:0] OPC_AND_LIT   = 8'hb5;
   localparam logic [7:0] OPC_LONG_CALL = 8'hb7;
   localparam logic [7:0] OPC_RET_LIT   = 8'hb6;
   localparam logic [6:0] OPC_ADD_FILE  = 7'h07;
   localparam logic [6:0] OPC_ADD_CY    = 7'h08;
   localparam logic [6:0] OPC_AND_FILE  = 7'h05;
   localparam logic [6:0] OPC_SET_FILE  = 7'h15;
   localparam logic [4:0] OPC_BIT_CLR   = 5'h11;
   localparam logic [4:0] OPC_SKIP_CLR  = 5'h13;
   localparam logic [4:0] OPC_SKIP_SET  = 5'h12;
   localparam logic [5:0] OPC_TBL_RD    = 6'h2a;
   localparam logic [5:0] OPC_TBL_WR    = 6'h2b;
   localparam logic [1:0] OPC_BRANCH    = 2'h3;
   localparam logic [15:0] OPC_RETURN   = 16'h0002;
   localparam logic [15:0] OPC_RETFIE   = 16'h0005;
   localparam logic [15:0] OPC_NOP      = 16'h0000;

   // File address of the program counter low byte.
   localparam logic [7:0] PC_LOW_FILE_ADDR = 8'h02;

   // ======================================================================
   // Status flag bit positions.
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;

   // ======================================================================
   // Register port offsets.
   localparam logic [2:0] REG_WORKING   = 3'h0;
   localparam logic [2:0] REG_STATUS    = 3'h1;
   localparam logic [2:0] REG_PC_LATCH  = 3'h2;
   localparam logic [2:0] REG_PC_LOW    = 3'h3;
   localparam logic [2:0] REG_PC_HIGH   = 3'h4;
   localparam logic [2:0] REG_CORE_STAT = 3'h5;

   localparam logic [7:0] RST_WORKING  = 8'h00;
   localparam logic [3:0] RST_FLAGS    = 4'h0;
   localparam logic [7:0] RST_PC_LATCH = 8'h00;
   localparam logic [15:0] RST_PC      = 16'h0000;

   // Extra no-operation cycles after the first.
   localparam logic [1:0] EXTRA_TWO_CYCLE   = 2'd1;
   localparam logic [1:0] EXTRA_THREE_CYCLE = 2'd2;

   // ======================================================================
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } cais_bus_req_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cais_mem_req_t;

endpackage

// ### cais_file_mem.sv
`timescale 1ns/100ps

module cais_file_mem #(
   parameter int DEPTH = 256
) (
   input  wire logic                  clk,
   input  wire logic                  ce,
   input  wire cais_pkg::cais_mem_req_t req,
   output logic [7:0]                  rdata
);

   logic [7:0] mem_q [DEPTH];

   // Read data are registered; a write and a read of one address in the
   // same cycle return the old value.
   always_ff @(posedge clk) begin
      if (ce) begin
         rdata <= mem_q[req.addr];
         if (req.we) begin
            mem_q[req.addr] <= req.wdata;
         end
      end
   end

endmodule

// ### cais_core.sv
`timescale 1ns/100ps

// Summary of operation
// - Add literal to working register, set flags.
// - Add working register to file register.
// - Add working, file and carry together.
// - Destination bit picks working or file.
// - AND literal into working, zero flag only.
// - AND working with file, zero flag only.
// - Clear selected file bit, flags untouched.
// - Signed arithmetic uses two's complement overflow.
// - s bit one writes file only.
// - Long call loads latch and literal.
// - Internal table write ends on interrupt.
// - Skips take two cycles when true.
// - Skip discards prefetched word, runs no-op.
// - Branches two cycles, table read to counter three.
module cais_core #(
   parameter int FILE_DEPTH = 256
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [15:0]  instr,
   input  wire logic         instr_valid,
   input  wire logic         tbl_internal,
   input  wire logic [15:0]  tbl_data,
   input  wire logic         irq_event,
   input  wire cais_pkg::cais_bus_req_t bus_req,
   output logic [7:0]        bus_rdata,
   output logic              instr_ack,
   output logic              discard,
   output logic              busy,
   output logic [15:0]       pc,
   output cais_pkg::cais_phase_t phase
);

   // ======================================================================
   // State.
   typedef struct packed {
      cais_pkg::cais_phase_t phase;
      logic [15:0]           ir;
      logic [7:0]            working_register;
      logic [3:0]            flags;
      logic [7:0]            pc_high_latch;
      logic [15:0]           pc;
      logic [7:0]            result;
      logic [3:0]            new_flags;
      logic                  skip_true;
      logic                  skip_pending;
      logic [1:0]            extra;
      logic                  tbl_wr_active;
      logic                  ack;
      logic                  discard;
      logic                  busy;
      logic [7:0]            rdata;
   } cais_state_t;

   cais_state_t q;
   cais_state_t d;

   cais_pkg::cais_mem_req_t mem_req;
   logic [7:0]              mem_rdata;
   cais_pkg::cais_op_t      op;
   logic [7:0]              alu_b;
   logic                    cin;
   logic [8:0]              sum9;
   logic [4:0]              nib5;
   logic [7:0]              and8;
   logic [7:0]              bit_mask;

   cais_file_mem #(
      .DEPTH (FILE_DEPTH)
   ) u_file_mem (
      .clk   (clk),
      .ce    (ce),
      .req   (mem_req),
      .rdata (mem_rdata)
   );

   // ======================================================================
   // Instruction decode.
   function automatic cais_pkg::cais_op_t decode(input logic [15:0] w);
      cais_pkg::cais_op_t o;
      o = cais_pkg::CAIS_OP_NOP;
      if (w[15:8] == cais_pkg::OPC_ADD_LIT) begin
         o = cais_pkg::CAIS_OP_ADD_LIT;
      end else if (w[15:8] == cais_pkg::OPC_AND_LIT) begin
         o = cais_pkg::CAIS_OP_AND_LIT;
      end else if (w[15:8] == cais_pkg::OPC_LONG_CALL) begin
         o = cais_pkg::CAIS_OP_LONG_CALL;
      end else if (w[15:8] == cais_pkg::OPC_RET_LIT || w == cais_pkg::OPC_RETURN ||
                   w == cais_pkg::OPC_RETFIE) begin
         o = cais_pkg::CAIS_OP_RET;
      end else if (w[15:9] == cais_pkg::OPC_ADD_FILE) begin
         o = cais_pkg::CAIS_OP_ADD_FILE;
      end else if (w[15:9] == cais_pkg::OPC_ADD_CY) begin
         o = cais_pkg::CAIS_OP_ADD_CY;
      end else if (w[15:9] == cais_pkg::OPC_AND_FILE) begin
         o = cais_pkg::CAIS_OP_AND_FILE;
      end else if (w[15:9] == cais_pkg::OPC_SET_FILE) begin
         o = cais_pkg::CAIS_OP_SET_FILE;
      end else if (w[15:11] == cais_pkg::OPC_BIT_CLR) begin
         o = cais_pkg::CAIS_OP_BIT_CLR;
      end else if (w[15:11] == cais_pkg::OPC_SKIP_CLR) begin
         o = cais_pkg::CAIS_OP_SKIP_CLR;
      end else if (w[15:11] == cais_pkg::OPC_SKIP_SET) begin
         o = cais_pkg::CAIS_OP_SKIP_SET;
      end else if (w[15:10] == cais_pkg::OPC_TBL_RD) begin
         o = cais_pkg::CAIS_OP_TBL_RD;
      end else if (w[15:10] == cais_pkg::OPC_TBL_WR) begin
         o = cais_pkg::CAIS_OP_TBL_WR;
      end else if (w[15:14] == cais_pkg::OPC_BRANCH) begin
         o = cais_pkg::CAIS_OP_BRANCH;
      end
      return o;
   endfunction

   // ======================================================================
   // Arithmetic, shared by all three add forms.
   always_comb begin
      op = decode(q.ir);
      if (op == cais_pkg::CAIS_OP_ADD_LIT || op == cais_pkg::CAIS_OP_AND_LIT) begin
         alu_b = q.ir[7:0];
      end else begin
         alu_b = mem_rdata;
      end
      cin      = (op == cais_pkg::CAIS_OP_ADD_CY) ? q.flags[cais_pkg::FLAG_C] : 1'b0;
      sum9     = {1'b0, q.working_register} + {1'b0, alu_b} + {8'h00, cin};
      nib5     = {1'b0, q.working_register[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
      and8     = q.working_register & alu_b;
      bit_mask = ~(8'h01 << q.ir[10:8]);
   end

   // ======================================================================
   // Sequencer.
   always_comb begin
      d       = q;
      d.ack   = 1'b0;
      d.discard = 1'b0;
      mem_req.we    = 1'b0;
      mem_req.addr  = q.ir[7:0];
      mem_req.wdata = q.result;

      if (bus_req.wr) begin
         if (bus_req.addr == cais_pkg::REG_WORKING) begin
            d.working_register = bus_req.wdata;
         end else if (bus_req.addr == cais_pkg::REG_STATUS) begin
            d.flags = bus_req.wdata[3:0];
         end else if (bus_req.addr == cais_pkg::REG_PC_LATCH) begin
            d.pc_high_latch = bus_req.wdata;
         end
      end
      if (bus_req.rd) begin
         if (bus_req.addr == cais_pkg::REG_WORKING) begin
            d.rdata = q.working_register;
         end else if (bus_req.addr == cais_pkg::REG_STATUS) begin
            d.rdata = {4'h0, q.flags};
         end else if (bus_req.addr == cais_pkg::REG_PC_LATCH) begin
            d.rdata = q.pc_high_latch;
         end else if (bus_req.addr == cais_pkg::REG_PC_LOW) begin
            d.rdata = q.pc[7:0];
         end else if (bus_req.addr == cais_pkg::REG_PC_HIGH) begin
            d.rdata = q.pc[15:8];
         end else if (bus_req.addr == cais_pkg::REG_CORE_STAT) begin
            d.rdata = {4'h0, q.tbl_wr_active, q.skip_pending, q.extra};
         end else begin
            d.rdata = 8'h00;
         end
      end

      // An interrupt event ends an internal table write in progress.
      if (irq_event) begin
         d.tbl_wr_active = 1'b0;
      end

      case (q.phase)
         cais_pkg::CAIS_Q1: begin
            d.phase = cais_pkg::CAIS_Q2;
            if (q.extra != 2'd0 || q.tbl_wr_active) begin
               d.ir = cais_pkg::OPC_NOP;
            end else if (instr_valid) begin
               d.ack = 1'b1;
               if (q.skip_pending) begin
                  // The prefetched word is consumed but never executed.
                  d.ir           = cais_pkg::OPC_NOP;
                  d.skip_pending = 1'b0;
                  d.discard      = 1'b1;
               end else begin
                  d.ir = instr;
               end
            end else begin
               d.ir = cais_pkg::OPC_NOP;
            end
         end
         cais_pkg::CAIS_Q2: begin
            // The file read issued now returns its data in Q3.
            d.phase = cais_pkg::CAIS_Q3;
         end
         cais_pkg::CAIS_Q3: begin
            d.phase     = cais_pkg::CAIS_Q4;
            d.new_flags = q.flags;
            d.result    = q.working_register;
            d.skip_true = 1'b0;
            case (op)
               cais_pkg::CAIS_OP_ADD_LIT, cais_pkg::CAIS_OP_ADD_FILE, cais_pkg::CAIS_OP_ADD_CY: begin
                  d.result                     = sum9[7:0];
                  d.new_flags[cais_pkg::FLAG_C]  = sum9[8];
                  d.new_flags[cais_pkg::FLAG_DC] = nib5[4];
                  d.new_flags[cais_pkg::FLAG_Z]  = (sum9[7:0] == 8'h00);
                  d.new_flags[cais_pkg::FLAG_OV] = (q.working_register[7] == alu_b[7]) &&
                                                   (sum9[7] != alu_b[7]);
               end
               cais_pkg::CAIS_OP_AND_LIT, cais_pkg::CAIS_OP_AND_FILE: begin
                  d.result                    = and8;
                  d.new_flags[cais_pkg::FLAG_Z] = (and8 == 8'h00);
               end
               cais_pkg::CAIS_OP_BIT_CLR: begin
                  d.result = mem_rdata & bit_mask;
               end
               cais_pkg::CAIS_OP_SET_FILE: begin
                  d.result = 8'hff;
               end
               cais_pkg::CAIS_OP_SKIP_CLR: begin
                  d.skip_true = ~mem_rdata[q.ir[10:8]];
               end
               cais_pkg::CAIS_OP_SKIP_SET: begin
                  d.skip_true = mem_rdata[q.ir[10:8]];
               end
               default: begin
                  d.result = q.working_register;
               end
            endcase
         end
         cais_pkg::CAIS_Q4: begin
            d.phase = cais_pkg::CAIS_Q1;
            d.pc    = q.pc + 16'h0001;
            if (q.extra != 2'd0) begin
               d.extra = q.extra - 2'd1;
            end
            case (op)
               cais_pkg::CAIS_OP_ADD_LIT, cais_pkg::CAIS_OP_AND_LIT: begin
                  d.working_register = q.result;
                  d.flags            = q.new_flags;
               end
               cais_pkg::CAIS_OP_ADD_FILE, cais_pkg::CAIS_OP_ADD_CY, cais_pkg::CAIS_OP_AND_FILE: begin
                  d.flags = q.new_flags;
                  if (q.ir[8]) begin
                     mem_req.we = 1'b1;
                  end else begin
                     d.working_register = q.result;
                  end
               end
               cais_pkg::CAIS_OP_BIT_CLR: begin
                  mem_req.we = 1'b1;
               end
               cais_pkg::CAIS_OP_SET_FILE: begin
                  mem_req.we = 1'b1;
                  if (!q.ir[8]) begin
                     d.working_register = q.result;
                  end
               end
               cais_pkg::CAIS_OP_SKIP_CLR, cais_pkg::CAIS_OP_SKIP_SET: begin
                  if (q.skip_true) begin
                     d.skip_pending = 1'b1;
                  end
               end
               cais_pkg::CAIS_OP_LONG_CALL: begin
                  d.pc    = {q.pc_high_latch, q.ir[7:0]};
                  d.extra = cais_pkg::EXTRA_TWO_CYCLE;
               end
               cais_pkg::CAIS_OP_BRANCH: begin
                  d.pc    = {q.pc[15:13], q.ir[12:0]};
                  d.extra = cais_pkg::EXTRA_TWO_CYCLE;
               end
               cais_pkg::CAIS_OP_RET: begin
                  d.extra = cais_pkg::EXTRA_TWO_CYCLE;
               end
               cais_pkg::CAIS_OP_TBL_RD: begin
                  if (q.ir[7:0] == cais_pkg::PC_LOW_FILE_ADDR) begin
                     d.pc    = {q.pc[15:8], tbl_data[7:0]};
                     d.extra = cais_pkg::EXTRA_THREE_CYCLE;
                  end else begin
                     d.extra = cais_pkg::EXTRA_TWO_CYCLE;
                  end
               end
               cais_pkg::CAIS_OP_TBL_WR: begin
                  if (tbl_internal) begin
                     // Set wins over a same-cycle interrupt clear.
                     d.tbl_wr_active = 1'b1;
                  end else begin
                     d.extra = cais_pkg::EXTRA_TWO_CYCLE;
                  end
               end
               default: begin
                  d.extra = d.extra;
               end
            endcase
            // The program counter stalls while extra cycles run.
            if (q.extra != 2'd0 || q.tbl_wr_active) begin
               d.pc = q.pc;
            end
         end
         default: begin
            d.phase = cais_pkg::CAIS_Q1;
         end
      endcase
      d.busy = (d.extra != 2'd0) || d.tbl_wr_active;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q                  <= '0;
         q.phase            <= cais_pkg::CAIS_Q1;
         q.working_register <= cais_pkg::RST_WORKING;
         q.flags            <= cais_pkg::RST_FLAGS;
         q.pc_high_latch    <= cais_pkg::RST_PC_LATCH;
         q.pc               <= cais_pkg::RST_PC;
      end else if (ce) begin
         q <= d;
      end
   end

   assign bus_rdata = q.rdata;
   assign instr_ack = q.ack;
   assign discard   = q.discard;
   assign busy      = q.busy;
   assign pc        = q.pc;
   assign phase     = q.phase;

endmodule

// ### cais_core_sva.sv
`timescale 1ns/100ps

// ======================================================================
// Port-level timing checks of the instruction core.
module cais_core_sva #(
   parameter int FILE_DEPTH = 256
) (
   input wire logic                    clk,
   input wire logic                    resetn,
   input wire logic                    ce,
   input wire logic [15:0]             instr,
   input wire logic                    instr_valid,
   input wire cais_pkg::cais_bus_req_t bus_req,
   input wire logic [7:0]              bus_rdata,
   input wire logic                    instr_ack,
   input wire logic                    discard,
   input wire logic                    busy,
   input wire cais_pkg::cais_phase_t   phase
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic take;
   assign take = ce && instr_valid && !busy && phase == cais_pkg::CAIS_Q1;

   // The sampled reset keeps the edge that releases reset out of this check.
   phase_step_a: assert property (resetn && ce |=> phase == 2'($past(phase) + 2'd1))
      else $error("phase did not advance by one");
   phase_hold_a: assert property (!ce |=> $stable(phase))
      else $error("phase moved while frozen");
   ack_take_a: assert property (take |=> instr_ack)
      else $error("taken word not acknowledged");
   ack_cause_a: assert property (instr_ack |-> $past(take))
      else $error("acknowledge without a taken word");
   ack_pulse_a: assert property (instr_ack |-> phase == cais_pkg::CAIS_Q2 ##1 !instr_ack)
      else $error("acknowledge not a single pulse in the second phase");
   discard_pair_a: assert property (discard |-> instr_ack)
      else $error("discard without acknowledge");
   busy_refuse_a: assert property (ce && busy && phase == cais_pkg::CAIS_Q1 |=> !instr_ack)
      else $error("word taken while busy");
   call_two_a: assert property (take && instr[15:8] == cais_pkg::OPC_LONG_CALL
      |-> ##4 busy && phase == cais_pkg::CAIS_Q1 ##4 !busy)
      else $error("long call not two cycles");
   tbl_pcl_a: assert property (take && instr[15:10] == cais_pkg::OPC_TBL_RD
      && instr[7:0] == cais_pkg::PC_LOW_FILE_ADDR |-> ##4 busy ##4 busy ##4 !busy)
      else $error("table read to counter not three cycles");
   rdata_hold_a: assert property (!bus_req.rd |=> $stable(bus_rdata))
      else $error("read data changed without a read");
endmodule

bind cais_core cais_core_sva #(.FILE_DEPTH(FILE_DEPTH)) u_sva (
   .clk(clk), .resetn(resetn), .ce(ce), .instr(instr), .instr_valid(instr_valid),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .instr_ack(instr_ack),
   .discard(discard), .busy(busy), .phase(phase));

// ### cais_core_tb_top.sv
`timescale 1ns/100ps

module cais_core_tb_top;
   logic                    clk;
   logic                    resetn;
   logic                    ce;
   logic [15:0]             instr;
   logic                    instr_valid;
   logic                    tbl_internal;
   logic [15:0]             tbl_data;
   logic                    irq_event;
   cais_pkg::cais_bus_req_t bus_req;
   logic [7:0]              bus_rdata;
   logic                    instr_ack;
   logic                    discard;
   logic                    busy;
   logic [15:0]             pc;
   cais_pkg::cais_phase_t   phase;
   int                      err_total;
   int                      num_checks;

   // Rows: working, literal, result, status.
   localparam logic [31:0] AL [3] = '{32'h10152500, 32'h7f01800a, 32'hff010007};
   // Rows: word, then cycle count in the low nibble.
   localparam logic [19:0] SP [7] = '{20'hb1011, 20'hb7342, 20'ha8023, 20'ha8102,
                                      20'hac102, 20'h00022, 20'hc0002};

   cais_core dut (
      .clk(clk), .resetn(resetn), .ce(ce), .instr(instr), .instr_valid(instr_valid),
      .tbl_internal(tbl_internal), .tbl_data(tbl_data), .irq_event(irq_event),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .instr_ack(instr_ack),
      .discard(discard), .busy(busy), .pc(pc), .phase(phase));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ======================================================================
   // Shared tasks.
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus_req <= '0;
   endtask

   task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus_req <= '0;
      #1;
      chk(nm, {8'h00, bus_rdata}, {8'h00, exp});
   endtask

   // Holds the word until it is acknowledged; the wait is bounded.
   task automatic issue(input logic [15:0] w, output logic disc);
      int n;
      n = 0;
      @(posedge clk);
      instr <= w;
      instr_valid <= 1'b1;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (instr_ack !== 1'b1 && n < 64);
      disc = discard;
      chk("ack_wait", 16'(n < 64), 16'h1);
   endtask

   // Returns once the result has been committed.
   task automatic run(input logic [15:0] w, output logic disc);
      issue(w, disc);
      @(posedge clk);
      instr_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ======================================================================
   // Scenarios.
   task automatic t_regs;
      rchk("w_rst", 3'h0, 8'h00);
      rchk("st_rst", 3'h1, 8'h00);
      rchk("latch_rst", 3'h2, 8'h00);
      wr(3'h5, 8'hff);
      rchk("core_ro", 3'h5, 8'h00);
      rchk("unmapped", 3'h6, 8'h00);
      wr(3'h2, 8'h12);
      rchk("latch_wr", 3'h2, 8'h12);
   endtask

   task automatic t_add_lit;
      logic d;
      for (int i = 0; i < 3; i++) begin
         wr(3'h0, AL[i][31:24]);
         wr(3'h1, 8'h00);
         run({8'hb1, AL[i][23:16]}, d);
         rchk("addlit_w", 3'h0, AL[i][15:8]);
         rchk("addlit_st", 3'h1, AL[i][7:0]);
      end
   endtask

   task automatic t_file;
      logic d;
      wr(3'h0, 8'h33);
      run(16'h2b20, d);
      rchk("set_s1_w", 3'h0, 8'h33);
      wr(3'h0, 8'h01);
      run(16'h0f20, d);
      rchk("add_d1_w", 3'h0, 8'h01);
      rchk("add_d1_st", 3'h1, 8'h07);
      wr(3'h0, 8'h05);
      run(16'h0e20, d);
      rchk("add_d0_w", 3'h0, 8'h05);
      rchk("add_d0_st", 3'h1, 8'h00);
      run(16'h2a21, d);
      rchk("set_s0_w", 3'h0, 8'hff);
   endtask

   task automatic t_carry;
      logic d;
      run(16'h2b20, d);
      for (int c = 1; c >= 0; c--) begin
         wr(3'h0, 8'h4d);
         wr(3'h1, 8'(c));
         run(16'h1020, d);
         rchk("addc_w", 3'h0, 8'h4c + 8'(c));
         rchk("addc_st", 3'h1, 8'h03);
      end
   endtask

   task automatic t_and;
      logic d;
      wr(3'h0, 8'ha3);
      wr(3'h1, 8'h0b);
      run(16'hb55f, d);
      rchk("andlit_w", 3'h0, 8'h03);
      rchk("andlit_st", 3'h1, 8'h0b);
      run(16'hb500, d);
      rchk("andlit_z", 3'h1, 8'h0f);
   endtask

   // File 0x30 ends as 0x42: bit 7 clear, bit 6 set, for the skip tests.
   task automatic t_bits;
      logic d;
      run(16'h2b30, d);
      wr(3'h1, 8'h0f);
      run(16'h8f30, d);
      run(16'h8830, d);
      rchk("bclr_st", 3'h1, 8'h0f);
      wr(3'h0, 8'hc3);
      run(16'h0b30, d);
      rchk("andf_d1_w", 3'h0, 8'hc3);
      wr(3'h0, 8'hff);
      run(16'h0a30, d);
      rchk("andf_d0_w", 3'h0, 8'h42);
      rchk("andf_st", 3'h1, 8'h0b);
   endtask

   task automatic t_skip(input logic [15:0] w, input logic dx, input logic [7:0] wx);
      logic d;
      wr(3'h0, 8'h00);
      run(w, d);
      run(16'hb101, d);
      chk("discard", {15'h0, d}, {15'h0, dx});
      rchk("skip_w", 3'h0, wx);
   endtask

   task automatic t_call;
      logic d;
      wr(3'h2, 8'h12);
      run(16'hb734, d);
      #1;
      chk("call_pc", pc, 16'h1234);
   endtask

   // Spacing of acknowledges with a no-op queued right behind the word.
   task automatic t_span;
      logic d;
      int   n;
      for (int i = 0; i < 7; i++) begin
         issue(SP[i][19:4], d);
         @(posedge clk);
         instr <= 16'h0000;
         n = 1;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (instr_ack !== 1'b1 && n < 64);
         chk("span", 16'(n), 16'(4 * SP[i][3:0]));
         @(posedge clk);
         instr_valid <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic t_tblwr;
      logic d;
      int   n;
      tbl_internal <= 1'b1;
      issue(16'hac10, d);
      @(posedge clk);
      instr_valid <= 1'b0;
      repeat (40) @(posedge clk);
      chk("tblwr_busy", {15'h0, busy}, 16'h1);
      irq_event <= 1'b1;
      @(posedge clk);
      irq_event <= 1'b0;
      for (n = 0; n < 16 && busy !== 1'b0; n++) @(posedge clk);
      chk("tblwr_end", {15'h0, busy}, 16'h0);
      tbl_internal <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end

   initial begin
      err_total = 0;
      num_checks = 0;
      resetn = 1'b0;
      ce = 1'b1;
      instr = 16'h0000;
      instr_valid = 1'b0;
      tbl_internal = 1'b0;
      tbl_data = 16'h00a5;
      irq_event = 1'b0;
      bus_req = '0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_add_lit();
      t_file();
      t_carry();
      t_and();
      t_bits();
      t_skip(16'h9f30, 1'b1, 8'h00);
      t_skip(16'h9e30, 1'b0, 8'h01);
      t_call();
      t_span();
      t_tblwr();
      @(posedge clk);
      ce <= 1'b0;
      repeat (8) @(posedge clk);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      test_done();
   end
endmodule
